// ### src/status_update_access_pkg.sv
// Package: register map, field layout, reset values and carrier types of the Status_update_access word
package status_update_access_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0]  ADDR_STATUS     = 4'h0;
  localparam logic [3:0]  ADDR_MASK       = 4'h1;
  localparam logic [3:0]  ADDR_FLAGS      = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h4;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int          ID_LSB          = 24;
  localparam int          ID_HW_BIT       = 31;
  localparam int          ID_LIB_BIT      = 30;
  localparam int          EN_LSB          = 16;
  localparam int          NAN_CTL_BIT     = 9;
  localparam int          FLAG_LSB        = 0;
  localparam int          NUM_EXC         = 5;

  // Writable bits: enables 20:16, NaN control 9, flags 4:0
  localparam logic [31:0] WRITABLE_MASK   = 32'h001F_021F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0]  EN_RESET        = 5'h1F;
  localparam logic [4:0]  FLAG_RESET      = 5'h00;
  localparam logic        NAN_CTL_RESET   = 1'h0;
  localparam logic [1:0]  IRQ_MASK_RESET  = 2'h0;

  // Identifier byte: arbitrary neutral value, hardware kind
  localparam logic [7:0]  SYS_ID_DEFAULT  = 8'hA5;

  // Interrupt status bits
  localparam int          IRQ_TRAP_BIT    = 0;
  localparam int          IRQ_FLAG_BIT    = 1;

  // Exception vector order: 4 inexact, 3 underflow, 2 overflow, 1 div-zero, 0 invalid
  typedef logic [NUM_EXC-1:0] exc_vec_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } bus_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RESP
  } bus_state_t;

  typedef struct packed {
    bus_state_t  bus_state;
    logic        waitrequest;
    logic [31:0] readdata;
    logic [31:0] mask_op;
    logic [31:0] flags_op;
    exc_vec_t    trap_en;
    exc_vec_t    flags;
    logic        nan_ctl;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
    logic        trap;
    exc_vec_t    trap_cause;
  } state_t;

endpackage : status_update_access_pkg

// ### src/fp_exception_status_word.sv
// FP exception status word with trap-enables, sticky flags and an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

module fp_exception_status_word
  import status_update_access_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire status_update_access_pkg::bus_req_t  bus_req_i,
  output var  status_update_access_pkg::bus_rsp_t  bus_rsp_o,
  input  wire logic                     exc_valid_i,
  input  wire status_update_access_pkg::exc_vec_t  exc_i,
  output logic                          trap_o,
  output status_update_access_pkg::exc_vec_t       trap_cause_o,
  output logic [31:0]                   status_o,
  output logic                          nan_ctl_o,
  output logic                          irq_o
);

  import status_update_access_pkg::*;

  state_t state;
  state_t next_state;

  // Builds the full word from the stored fields
  function automatic logic [31:0] pack_word(input exc_vec_t en, input logic nan, input exc_vec_t fl);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ID_LSB +: 8] = SYS_ID_DEFAULT;
    w[EN_LSB +: NUM_EXC] = en;
    w[NAN_CTL_BIT] = nan;
    w[FLAG_LSB +: NUM_EXC] = fl;
    return w;
  endfunction

  logic [31:0] cur_word;
  logic [31:0] upd_word;
  exc_vec_t    exc_hit;
  exc_vec_t    exc_flag_set;
  exc_vec_t    exc_trap;
  logic        access_go;

  always_comb begin
    cur_word     = pack_word(state.trap_en, state.nan_ctl, state.flags);
    // Masked to writable bits so identifier and reserved bits never move
    upd_word     = ((cur_word & ~state.mask_op) ^ state.flags_op) & WRITABLE_MASK;
    exc_hit      = exc_valid_i ? exc_i : '0;
    exc_flag_set = exc_hit & ~state.trap_en;
    exc_trap     = exc_hit & state.trap_en;
    access_go    = 1'b0;

    next_state             = state;
    next_state.waitrequest = 1'b1;
    next_state.trap        = |exc_trap;
    next_state.trap_cause  = exc_trap;

    // ****************************************
    // Bus slave
    // ****************************************
    case (state.bus_state)
      ST_IDLE: begin
        if (bus_req_i.read || bus_req_i.write) begin
          next_state.bus_state   = ST_RESP;
          next_state.waitrequest = 1'b0;
          next_state.readdata    = 32'h0000_0000;
          if (bus_req_i.write) begin
            case (bus_req_i.address)
              ADDR_MASK:     next_state.mask_op  = bus_req_i.writedata;
              ADDR_FLAGS:    next_state.flags_op = bus_req_i.writedata;
              ADDR_STATUS:   access_go = 1'b1;
              ADDR_IRQ_MASK: next_state.irq_mask = bus_req_i.writedata[1:0];
              default: ;
            endcase
          end else begin
            case (bus_req_i.address)
              // A read of the status address is the update access itself
              ADDR_STATUS: begin
                next_state.readdata = cur_word;
                access_go = 1'b1;
              end
              ADDR_MASK:     next_state.readdata = state.mask_op;
              ADDR_FLAGS:    next_state.readdata = state.flags_op;
              ADDR_IRQ_STAT: next_state.readdata = {30'h0, state.irq_stat};
              ADDR_IRQ_MASK: next_state.readdata = {30'h0, state.irq_mask};
              default:       next_state.readdata = 32'h0000_0000;
            endcase
          end
        end
      end
      ST_RESP: begin
        // Gap cycle: master drops its request at the answering edge
        next_state.bus_state = ST_IDLE;
      end
      default: next_state.bus_state = ST_IDLE;
    endcase

    // ****************************************
    // Status word update
    // ****************************************
    if (access_go) begin
      next_state.trap_en = upd_word[EN_LSB +: NUM_EXC];
      next_state.nan_ctl = upd_word[NAN_CTL_BIT];
      next_state.flags   = upd_word[FLAG_LSB +: NUM_EXC];
    end
    // Hardware set beats a same-cycle software clear
    next_state.flags = next_state.flags | exc_flag_set;

    // ****************************************
    // Interrupts
    // ****************************************
    if (bus_req_i.write && state.bus_state == ST_IDLE && bus_req_i.address == ADDR_IRQ_STAT) begin
      next_state.irq_stat = state.irq_stat & ~bus_req_i.writedata[1:0];
    end
    if (|exc_trap) begin
      next_state.irq_stat[IRQ_TRAP_BIT] = 1'b1;
    end
    if (|exc_flag_set) begin
      next_state.irq_stat[IRQ_FLAG_BIT] = 1'b1;
    end
    next_state.irq = |(next_state.irq_stat & state.irq_mask);

    if (rst_i) begin
      next_state             = '0;
      next_state.bus_state   = ST_IDLE;
      next_state.waitrequest = 1'b1;
      next_state.trap_en     = EN_RESET;
      next_state.flags       = FLAG_RESET;
      next_state.nan_ctl     = NAN_CTL_RESET;
      next_state.irq_mask    = IRQ_MASK_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  always_comb begin
    bus_rsp_o.waitrequest = state.waitrequest;
    bus_rsp_o.readdata    = state.readdata;
    trap_o                = state.trap;
    trap_cause_o          = state.trap_cause;
    status_o              = pack_word(state.trap_en, state.nan_ctl, state.flags);
    nan_ctl_o             = state.nan_ctl;
    irq_o                 = state.irq;
  end

endmodule // fp_exception_status_word

`default_nettype wire

// ### verif/status_update_access_assertions.sv
// Checker: port-level properties of the Status_update_access word
`timescale 1ns/1ps
`default_nettype none
module status_update_access_assertions
  import status_update_access_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire status_update_access_pkg::bus_req_t bus_req_i,
  input wire status_update_access_pkg::bus_rsp_t bus_rsp_o,
  input wire logic                    exc_valid_i,
  input wire status_update_access_pkg::exc_vec_t exc_i,
  input wire logic                    trap_o,
  input wire status_update_access_pkg::exc_vec_t trap_cause_o,
  input wire logic [31:0]             status_o,
  input wire logic                    nan_ctl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Gap cycle after an answer is excluded, as the slave ignores it
  sequence taken_s;
    (bus_req_i.read || bus_req_i.write) && bus_rsp_o.waitrequest && $past(bus_rsp_o.waitrequest);
  endsequence
  ack_once_a: assert property (taken_s |=> !bus_rsp_o.waitrequest ##1 bus_rsp_o.waitrequest)
    else $error("bus answer not one cycle");
  old_word_a: assert property (taken_s ##0 (bus_req_i.read && bus_req_i.address == ADDR_STATUS)
    |=> bus_rsp_o.readdata == $past(status_o)) else $error("status read not old word");
  id_fixed_a: assert property (status_o[31:24] == SYS_ID_DEFAULT) else $error("id byte moved");
  resv_zero_a: assert property ((status_o & ~WRITABLE_MASK & 32'h00FF_FFFF) == 32'h0)
    else $error("reserved bit set");
  reset_val_a: assert property ($fell(rst_i) |-> status_o[20:16] == EN_RESET && status_o[4:0] == FLAG_RESET)
    else $error("bad reset word");
  trap_cause_a: assert property (exc_valid_i |=> trap_o == |($past(exc_i) & $past(status_o[20:16]))
    && trap_cause_o == ($past(exc_i) & $past(status_o[20:16]))) else $error("trap mismatch");
  idle_trap_a: assert property (!exc_valid_i |=> !trap_o) else $error("trap without exception");
  flag_set_a: assert property (exc_valid_i |=> (status_o[4:0] & $past(exc_i) & ~$past(status_o[20:16]))
    == ($past(exc_i) & ~$past(status_o[20:16]))) else $error("flag not set");
  // A reset in mid-run clears the flags legally, so the edge right after it is left out
  sticky_a: assert property (!$past(rst_i) && |($past(status_o[4:0]) & ~status_o[4:0]) |-> !bus_rsp_o.waitrequest)
    else $error("flag dropped");
  nan_bit_a: assert property (nan_ctl_o == status_o[9]) else $error("nan control mismatch");
endmodule // status_update_access_assertions
bind fp_exception_status_word status_update_access_assertions chk_u (.clk_i, .rst_i, .bus_req_i, .bus_rsp_o, .exc_valid_i,
  .exc_i, .trap_o, .trap_cause_o, .status_o, .nan_ctl_o);
`default_nettype wire

// ### verif/tb_top.sv
// Testbench: random and corner accesses to the Status_update_access word
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import status_update_access_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  bus_req_t    bus_req = '0;
  bus_rsp_t    bus_rsp;
  logic        exc_valid = 1'b0;
  exc_vec_t    exc_v = '0;
  logic        trap;
  exc_vec_t    cause;
  logic [31:0] status;
  logic        nan_ctl;
  logic        irq;
  logic [31:0] m;
  logic [31:0] q;
  logic [1:0]  irqs = 2'h0;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  fp_exception_status_word dut_u (.clk_i, .rst_i, .bus_req_i(bus_req), .bus_rsp_o(bus_rsp), .exc_valid_i(exc_valid),
    .exc_i(exc_v), .trap_o(trap), .trap_cause_o(cause), .status_o(status), .nan_ctl_o(nan_ctl), .irq_o(irq));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low, then leaves one idle cycle
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    bus_req <= '{read: !wr, write: wr, address: a, writedata: d};
    do @(posedge clk_i); while (bus_rsp.waitrequest !== 1'b0);
    q = bus_rsp.readdata;
    bus_req <= '0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] upd(logic [31:0] o, logic [31:0] mk, logic [31:0] fl);
    return (o & ~WRITABLE_MASK) | (((o & ~mk) ^ fl) & WRITABLE_MASK);
  endfunction
  task automatic acc(input logic [31:0] mk, input logic [31:0] fl);
    bus(1'b1, ADDR_MASK, mk);
    bus(1'b1, ADDR_FLAGS, fl);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, m);
    m = upd(m, mk, fl);
    chk(status, m);
    chk(32'(nan_ctl), 32'(m[9]));
  endtask
  task automatic exc(input exc_vec_t v);
    exc_vec_t te;
    te = v & m[20:16];
    exc_valid <= 1'b1;
    exc_v <= v;
    @(posedge clk_i);
    exc_valid <= 1'b0;
    @(negedge clk_i);
    chk(32'({trap, cause}), 32'({|te, te}));
    irqs = irqs | {|(v & ~m[20:16]), |te};
    m[4:0] = m[4:0] | (v & ~m[20:16]);
    chk(status, m);
    @(posedge clk_i);
  endtask
  initial begin
    void'($urandom(42582));
    m = {SYS_ID_DEFAULT, 3'h0, EN_RESET, 6'h0, NAN_CTL_RESET, 4'h0, FLAG_RESET};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(status, m);
    chk(32'(status[31]), 32'h1);
    acc(32'hFFFF_FFFF, 32'hFFFF_FFFF);
    acc(32'hFFFF_FFFF, 32'h0);
    acc(32'h0, 32'hFFFF_FFFF);
    acc(32'h0, 32'h0);
    acc(32'h001F_0000, 32'h0005_0000);
    exc(5'h1F);
    repeat (12) begin
      acc($urandom, $urandom);
      exc(exc_vec_t'($urandom));
    end
    chk(32'(irq), 32'h0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'(|irqs));
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'(irqs));
    bus(1'b1, ADDR_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    bus(1'b0, 4'hF, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    chk(status, m);
    // Reset again in mid-run: enables back on, flags and interrupt state cleared
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    m = {SYS_ID_DEFAULT, 3'h0, EN_RESET, 6'h0, NAN_CTL_RESET, 4'h0, FLAG_RESET};
    chk(status, m);
    chk(32'({irq, trap}), 32'h0);
    acc(32'h0, 32'h0000_0011);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
